// File: sbr_pkg.sv
/*
  Shared constants and types for the SPI follower link with busy pacing
  and read-request signalling. Assumes a 40 MHz system clock on both ends.
*/
package sbr_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 25000;   // 40 MHz system clock
  localparam int BUSY_DELAY_NS     = 1140;    // least gap select-high to busy
  localparam int BUSY_HIGH_NS      = 3300;    // least busy high time
  localparam int LEADER_MAX_BUSYWAIT_NS = 27040; // leader tolerance to busy rise
  localparam int LEADER_MAX_BUSYHIGH_NS = 33040; // leader tolerance busy high
  localparam int SCLK_MAX_HZ       = 10000000;
  localparam int SYS_CLK_HZ        = 40000000;

  // least times round up
  localparam int BUSY_DELAY_CYC = (BUSY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_HIGH_CYC  = (BUSY_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest times round down
  localparam int LEADER_BUSYWAIT_CYC = (LEADER_MAX_BUSYWAIT_NS * 1000) / CLK_PERIOD_PS;
  localparam int LEADER_BUSYHIGH_CYC = (LEADER_MAX_BUSYHIGH_NS * 1000) / CLK_PERIOD_PS;
  // leader clock divider: the follower answers a clock fall through its synchroniser,
  // its output flop and the leader's synchroniser, seven cycles in all, so a half
  // period lasts at least that long; sclk then stays well under 10 MHz
  localparam int MISO_TURN_CYC = 7;
  localparam int SCLK_MIN_HALF = SYS_CLK_HZ / (2 * SCLK_MAX_HZ);
  localparam int SCLK_HALF_CYC = (MISO_TURN_CYC > SCLK_MIN_HALF) ? MISO_TURN_CYC : SCLK_MIN_HALF;

  localparam int TIMER_W = 12;
  localparam logic [TIMER_W-1:0] BUSY_DELAY_CNT = TIMER_W'(BUSY_DELAY_CYC);
  localparam logic [TIMER_W-1:0] BUSY_HIGH_CNT  = TIMER_W'(BUSY_HIGH_CYC);
  localparam logic [TIMER_W-1:0] LEADER_WAIT_CNT = TIMER_W'(LEADER_BUSYWAIT_CYC);
  localparam logic [TIMER_W-1:0] LEADER_HIGH_CNT = TIMER_W'(LEADER_BUSYHIGH_CYC);
  localparam logic [3:0] SCLK_HALF_CNT = 4'(SCLK_HALF_CYC - 1); // counts down to zero

  // ----------------------------------------------------------------------
  // framing and straps
  // ----------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [2:0] LINK_TYPE_SPI = 3'h2;   // straps bit2..bit0 = 0,1,0
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [7:0] FILL_BYTE     = 8'hFF;  // sent when nothing is prepared
  localparam logic [7:0] CNT_ZERO      = 8'h00;
  localparam logic [7:0] FLUSH_MAX_BYTES = 8'h01; // 0 or 1 byte frame is a flush

  // follower read-side state
  typedef enum logic [1:0] {
    RD_IDLE,      // nothing pending
    RD_REQUEST,   // read request raised, waiting for acknowledge
    RD_READY      // acknowledged, data may be read
  } sbr_rd_type;

  // leader sequencer state
  typedef enum logic [2:0] {
    LD_IDLE,
    LD_SELECT,
    LD_SHIFT,
    LD_DESELECT,
    LD_WAIT_BUSY_RISE,
    LD_WAIT_BUSY_FALL
  } sbr_ld_type;

  // frame counts in bytes, saturating
  function automatic logic [7:0] sbr_sat_inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

endpackage

// File: sbr_link_if.sv
/*
  Link wires between the SPI leader and the SPI follower.
  Assumes the bench resolves the follower data line from its enable.
*/
`timescale 1ns/1ps
interface sbr_link_if;
  logic selectN;               // follower_select_n
  logic serialClock;           // serial_clock_in
  logic leaderToFollowerData;
  logic followerToLeaderData;
  logic followerToLeaderDataOe;
  logic busy;
  logic readRequestFlag;

  modport follower (
    input  selectN,
    input  serialClock,
    input  leaderToFollowerData,
    output followerToLeaderData,
    output followerToLeaderDataOe,
    output busy,
    output readRequestFlag
  );

  modport leader (
    output selectN,
    output serialClock,
    output leaderToFollowerData,
    input  followerToLeaderData,
    input  followerToLeaderDataOe,
    input  busy,
    input  readRequestFlag
  );
endinterface

// File: sbr_follower.sv
/*
  SPI follower end: mode 0 shifter, busy pacing, read-request flag and
  flush handling. Assumes link pins are asynchronous to clk_sys and are
  synchronised here; the leader keeps its own pacing duties.
*/
`timescale 1ns/1ps
module sbr_follower (
  // system
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // link
  sbr_link_if.follower    link,
  // strap
  input  wire logic [2:0] linkTypeSelect,
  // outbound message side
  input  wire logic       msgPending,
  input  wire logic [7:0] txByte,
  output logic            txByteTaken,
  // inbound side
  output logic [7:0]      rxByte,
  output logic            rxByteValid,
  output logic            frameDone,
  output logic            flushSeen,
  output logic            spiSelected
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic [2:0] syncPrev_reg;

  // two stages plus an edge stage; logic looks at the second stage and its one-cycle-delayed copy
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncA_reg    <= 3'h4;   // idle levels: deselected, clock low
      syncB_reg    <= 3'h4;
      syncPrev_reg <= 3'h4;
    end else begin
      syncA_reg    <= {link.selectN, link.serialClock, link.leaderToFollowerData};
      syncB_reg    <= syncA_reg;
      syncPrev_reg <= syncB_reg;
    end
  end

  logic selN;
  logic sclkRise;
  logic sclkFall;
  logic selFall;
  logic selRise;
  assign selN     = syncB_reg[2];
  assign selFall  = syncPrev_reg[2] && !selN;
  assign selRise  = !syncPrev_reg[2] && selN;
  assign sclkRise = !selN && !syncPrev_reg[1] && syncB_reg[1];
  assign sclkFall = !selN && syncPrev_reg[1] && !syncB_reg[1];

  logic [2:0] strapA_reg;
  logic [2:0] strapB_reg;

  // straps are pins too: two stages before the compare
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strapA_reg  <= 3'h0;
      strapB_reg  <= 3'h0;
      spiSelected <= 1'b0;
    end else begin
      strapA_reg  <= linkTypeSelect;
      strapB_reg  <= strapA_reg;
      spiSelected <= (strapB_reg == sbr_pkg::LINK_TYPE_SPI);
    end
  end

  // ----------------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------------
  logic [2:0] bitCnt_reg;
  logic [7:0] rxShift_reg;
  logic [7:0] txShift_reg;
  logic [7:0] byteCnt_reg;
  logic [7:0] txLoad;
  sbr_pkg::sbr_rd_type rdState_reg;  // read side state, also gates txByteTaken

  // nothing prepared or flushed away: send the fill byte
  assign txLoad = msgPending ? txByte : sbr_pkg::FILL_BYTE;

  // receive samples on rising edge, transmit changes on falling edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bitCnt_reg  <= 3'h0;
      rxShift_reg <= sbr_pkg::BYTE_RESET;
      txShift_reg <= sbr_pkg::FILL_BYTE;
      byteCnt_reg <= sbr_pkg::CNT_ZERO;
      rxByte      <= sbr_pkg::BYTE_RESET;
      rxByteValid <= 1'b0;
      txByteTaken <= 1'b0;
    end else begin
      rxByteValid <= 1'b0;
      txByteTaken <= 1'b0;
      if (selFall) begin
        bitCnt_reg  <= 3'h0;
        byteCnt_reg <= sbr_pkg::CNT_ZERO;
        txShift_reg <= txLoad;          // first bit ready before first rise
        txByteTaken <= msgPending && rdState_reg == sbr_pkg::RD_READY;
      end else if (sclkRise) begin
        rxShift_reg <= {rxShift_reg[6:0], syncB_reg[0]};
        bitCnt_reg  <= bitCnt_reg + 3'h1;
        if (bitCnt_reg == 3'h7) begin
          rxByte      <= {rxShift_reg[6:0], syncB_reg[0]};
          rxByteValid <= 1'b1;
          byteCnt_reg <= sbr_pkg::sbr_sat_inc(byteCnt_reg);
        end
      end else if (sclkFall) begin
        if (bitCnt_reg == 3'h0) begin
          txShift_reg <= txLoad;
          txByteTaken <= msgPending && rdState_reg == sbr_pkg::RD_READY;
        end else begin
          txShift_reg <= {txShift_reg[6:0], 1'b1};
        end
      end
    end
  end

  // data pin released while deselected
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link.followerToLeaderDataOe <= 1'b0;
      link.followerToLeaderData   <= 1'b0;
    end else begin
      link.followerToLeaderDataOe <= !selN;
      link.followerToLeaderData   <= txShift_reg[7];
    end
  end

  // ----------------------------------------------------------------------
  // frame end, flush and read request
  // ----------------------------------------------------------------------
  logic        isFlush;
  assign isFlush = byteCnt_reg <= sbr_pkg::FLUSH_MAX_BYTES;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frameDone <= 1'b0;
      flushSeen <= 1'b0;
    end else begin
      frameDone <= selRise;
      flushSeen <= selRise && isFlush;  // tells the message side to discard
    end
  end

  // read state: request raised at any time, even mid write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdState_reg <= sbr_pkg::RD_IDLE;
    end else begin
      case (rdState_reg)
        sbr_pkg::RD_IDLE: begin
          // message side drops msgPending a cycle after flushSeen: no stale request
          if (msgPending && !selRise && !flushSeen) begin
            rdState_reg <= sbr_pkg::RD_REQUEST;
          end
        end
        sbr_pkg::RD_REQUEST: begin
          if (selRise) begin
            // two or more bytes acknowledge; a 0 or 1 byte flush ends the read
            rdState_reg <= isFlush ? sbr_pkg::RD_IDLE : sbr_pkg::RD_READY;
          end
        end
        sbr_pkg::RD_READY: begin
          if (selRise && (isFlush || !msgPending)) begin
            rdState_reg <= sbr_pkg::RD_IDLE;
          end
        end
        default: rdState_reg <= sbr_pkg::RD_IDLE;
      endcase
    end
  end

  // flag high only while a request awaits acknowledge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link.readRequestFlag <= 1'b0;
    end else begin
      link.readRequestFlag <= (rdState_reg == sbr_pkg::RD_REQUEST) && !selRise;
    end
  end

  // ----------------------------------------------------------------------
  // busy pacing
  // ----------------------------------------------------------------------
  logic [sbr_pkg::TIMER_W-1:0] busyTimer_reg;
  logic [1:0]                  busyPhase_reg;  // 0 idle, 1 delay, 2 high

  // busy runs only from a transaction end, never for anything else
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busyPhase_reg <= 2'h0;
      busyTimer_reg <= '0;
      link.busy     <= 1'b0;
    end else begin
      case (busyPhase_reg)
        2'h0: begin
          if (selRise) begin
            busyPhase_reg <= 2'h1;
            busyTimer_reg <= sbr_pkg::BUSY_DELAY_CNT;
          end
        end
        2'h1: begin
          if (busyTimer_reg <= 12'h001) begin
            busyPhase_reg <= 2'h2;
            busyTimer_reg <= sbr_pkg::BUSY_HIGH_CNT;
            link.busy     <= 1'b1;
          end else begin
            busyTimer_reg <= busyTimer_reg - 12'h001;
          end
        end
        2'h2: begin
          if (busyTimer_reg <= 12'h001) begin
            busyPhase_reg <= 2'h0;
            link.busy     <= 1'b0;  // falling edge: ready for next
          end else begin
            busyTimer_reg <= busyTimer_reg - 12'h001;
          end
        end
        default: begin
          busyPhase_reg <= 2'h0;
          link.busy     <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: sbr_leader.sv
/*
  SPI leader end: drives mode 0 frames from a byte command port, waits
  on busy between frames and reports the read-request flag rise.
  Assumes busy and flag come from another clock domain.
*/
`timescale 1ns/1ps
module sbr_leader (
  // system
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // link
  sbr_link_if.leader      link,
  // command: frame of frameLen bytes (0 allowed: flush)
  input  wire logic       startValid,
  input  wire logic [7:0] frameLen,
  input  wire logic [7:0] txByte,
  output logic            startReady,
  output logic            txByteTaken,
  output logic [7:0]      rxByte,
  output logic            rxByteValid,
  output logic            frameDone,
  output logic            readRequestRise,
  output logic            busyTimeout
);

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic       flagPrev_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncA_reg    <= 3'h0;
      syncB_reg    <= 3'h0;
      flagPrev_reg <= 1'b0;
    end else begin
      syncA_reg    <= {link.busy, link.readRequestFlag, link.followerToLeaderData};
      syncB_reg    <= syncA_reg;
      flagPrev_reg <= syncB_reg[1];
    end
  end

  // interrupt style event on flag rise
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      readRequestRise <= 1'b0;
    end else begin
      readRequestRise <= syncB_reg[1] && !flagPrev_reg;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  sbr_pkg::sbr_ld_type state_reg;
  logic [3:0]  divCnt_reg;
  logic [2:0]  bitCnt_reg;
  logic [7:0]  bytesLeft_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  rxShift_reg;
  logic [sbr_pkg::TIMER_W-1:0] waitCnt_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg                 <= sbr_pkg::LD_IDLE;
      divCnt_reg                <= 4'h0;
      bitCnt_reg                <= 3'h0;
      bytesLeft_reg             <= 8'h00;
      shift_reg                 <= 8'h00;
      rxShift_reg               <= 8'h00;
      waitCnt_reg               <= '0;
      link.selectN              <= 1'b1;
      link.serialClock          <= 1'b0;  // mode 0 idles low
      link.leaderToFollowerData <= 1'b0;
      startReady                <= 1'b0;
      txByteTaken               <= 1'b0;
      rxByte                    <= 8'h00;
      rxByteValid               <= 1'b0;
      frameDone                 <= 1'b0;
      busyTimeout               <= 1'b0;
    end else begin
      txByteTaken <= 1'b0;
      rxByteValid <= 1'b0;
      frameDone   <= 1'b0;
      busyTimeout <= 1'b0;
      case (state_reg)
        sbr_pkg::LD_IDLE: begin
          // never start while busy is high
          startReady <= !syncB_reg[2];
          if (startValid && startReady && !syncB_reg[2]) begin
            startReady    <= 1'b0;
            bytesLeft_reg <= frameLen;
            link.selectN  <= 1'b0;
            divCnt_reg    <= sbr_pkg::SCLK_HALF_CNT;
            state_reg     <= sbr_pkg::LD_SELECT;
          end
        end
        sbr_pkg::LD_SELECT: begin
          if (divCnt_reg != 4'h0) begin
            divCnt_reg <= divCnt_reg - 4'h1;
          end else if (bytesLeft_reg == 8'h00) begin
            state_reg <= sbr_pkg::LD_DESELECT;     // zero byte flush
          end else begin
            shift_reg                 <= {txByte[6:0], 1'b0};
            link.leaderToFollowerData <= txByte[7];
            txByteTaken               <= 1'b1;
            bitCnt_reg                <= 3'h0;
            divCnt_reg                <= sbr_pkg::SCLK_HALF_CNT;
            state_reg                 <= sbr_pkg::LD_SHIFT;
          end
        end
        sbr_pkg::LD_SHIFT: begin
          // divider from clk_sys keeps sclk at most 10 MHz
          if (divCnt_reg != 4'h0) begin
            divCnt_reg <= divCnt_reg - 4'h1;
          end else if (!link.serialClock) begin
            link.serialClock <= 1'b1;
            rxShift_reg      <= {rxShift_reg[6:0], syncB_reg[0]};
            divCnt_reg       <= sbr_pkg::SCLK_HALF_CNT;
          end else begin
            link.serialClock <= 1'b0;
            divCnt_reg       <= sbr_pkg::SCLK_HALF_CNT;
            bitCnt_reg       <= bitCnt_reg + 3'h1;
            if (bitCnt_reg == 3'h7) begin
              rxByte        <= rxShift_reg;
              rxByteValid   <= 1'b1;
              bytesLeft_reg <= bytesLeft_reg - 8'h01;
              state_reg     <= sbr_pkg::LD_SELECT;
              divCnt_reg    <= 4'h0;
            end else begin
              link.leaderToFollowerData <= shift_reg[7];
              shift_reg                 <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        sbr_pkg::LD_DESELECT: begin
          link.selectN <= 1'b1;
          frameDone    <= 1'b1;
          waitCnt_reg  <= sbr_pkg::LEADER_WAIT_CNT;
          state_reg    <= sbr_pkg::LD_WAIT_BUSY_RISE;
        end
        sbr_pkg::LD_WAIT_BUSY_RISE: begin
          // tolerate the empirical activation bound
          if (syncB_reg[2]) begin
            waitCnt_reg <= sbr_pkg::LEADER_HIGH_CNT;
            state_reg   <= sbr_pkg::LD_WAIT_BUSY_FALL;
          end else if (waitCnt_reg == '0) begin
            busyTimeout <= 1'b1;
            state_reg   <= sbr_pkg::LD_IDLE;
          end else begin
            waitCnt_reg <= waitCnt_reg - 12'h001;
          end
        end
        sbr_pkg::LD_WAIT_BUSY_FALL: begin
          if (!syncB_reg[2]) begin
            state_reg <= sbr_pkg::LD_IDLE;
          end else if (waitCnt_reg == '0) begin
            busyTimeout <= 1'b1;
            waitCnt_reg <= sbr_pkg::LEADER_HIGH_CNT;
          end else begin
            waitCnt_reg <= waitCnt_reg - 12'h001;
          end
        end
        default: state_reg <= sbr_pkg::LD_IDLE;
      endcase
    end
  end

endmodule

// File: sbr_link_sva.sv
/*
  Checker for the link wires between leader and follower.
  Assumes both ends run on clk_sys and sit beside this instance.
*/
`timescale 1ns/1ps
module sbr_link_sva (
  // system
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link
  input wire logic selectN,
  input wire logic serialClock,
  input wire logic followerToLeaderDataOe,
  input wire logic busy,
  input wire logic readRequestFlag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic [11:0] gapReg;   // cycles since select went high
  logic [11:0] highReg;  // cycles busy has stood high
  logic        pendReg;  // a frame ended, busy still owed

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // saturating, so a long idle spell never wraps back under the limit
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !selectN) gapReg <= 12'h000;
    else if (gapReg != 12'hFFF) gapReg <= gapReg + 12'h001;
  end

  // busy high time, cleared while low
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !busy) highReg <= 12'h000;
    else highReg <= highReg + 12'h001;
  end

  // a frame end owes one busy pulse
  always_ff @(posedge clk_sys) begin
    if (sys_rst) pendReg <= 1'b0;
    else if ($rose(selectN)) pendReg <= 1'b1;
    else if (busy) pendReg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_busy_delay: assert property (
    $rose(busy) |-> gapReg >= sbr_pkg::BUSY_DELAY_CYC)
    else $error("busy rose too soon after deselect");
  chk_busy_hold: assert property (
    $fell(busy) |-> highReg == sbr_pkg::BUSY_HIGH_CYC)
    else $error("busy high time wrong");
  chk_busy_cause: assert property (
    $rose(busy) |-> pendReg)
    else $error("busy rose without a frame");
  chk_busy_follows: assert property (
    pendReg |-> gapReg <= 12'(sbr_pkg::LEADER_BUSYWAIT_CYC))
    else $error("busy never rose after frame");
  chk_busy_release: assert property (
    $rose(busy) |-> ##[1:1000] !busy)
    else $error("busy stuck high");
  chk_start_idle: assert property (
    $fell(selectN) |-> !busy && !pendReg)
    else $error("frame started while busy owed");
  chk_sclk_framed: assert property (
    serialClock |-> !selectN)
    else $error("serial clock outside frame");
  chk_sclk_rate: assert property (
    $rose(serialClock) |=> (!$rose(serialClock)) [*3])
    else $error("serial clock too fast");
  chk_miso_float: assert property (
    selectN && $past(selectN, 8) |-> !followerToLeaderDataOe)
    else $error("data driven while deselected");
  chk_flag_ack: assert property (
    readRequestFlag && $rose(selectN) |-> ##[1:40] !readRequestFlag)
    else $error("read request not dropped");

  // main scenarios
  cover property ($fell(busy));
  cover property ($rose(readRequestFlag));
  cover property ($rose(selectN) && readRequestFlag);
endmodule

// File: test_spi_follower_busy_read_request_flag_link.sv
/*
  Self-checking bench: leader and follower joined by the link interface.
  Assumes the package constants and one 40 MHz clock for both ends.
*/
`timescale 1ns/1ps
module test_spi_follower_busy_read_request_flag_link;
  logic       clk_sys, sys_rst, startValid, startReady, msgPending, ignoreRx;
  logic       lRxValid, fRxValid, fFlush, spiSel, busyTo;
  logic [7:0] frameLen, ldByte, rdByte, lRx, fRx, wireSh;
  logic [2:0] linkTypeSelect;
  logic [7:0] fq[$], lq[$];
  int         bad_count, n_checks, flushCnt, seed, wireBits;

  sbr_link_if link ();
  sbr_leader i_sbr_leader (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.leader),
    .startValid(startValid), .frameLen(frameLen), .txByte(ldByte), .startReady(startReady),
    .txByteTaken(), .rxByte(lRx), .rxByteValid(lRxValid), .frameDone(),
    .readRequestRise(), .busyTimeout(busyTo));
  sbr_follower i_sbr_follower (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.follower),
    .linkTypeSelect(linkTypeSelect), .msgPending(msgPending), .txByte(rdByte),
    .txByteTaken(), .rxByte(fRx), .rxByteValid(fRxValid), .frameDone(),
    .flushSeen(fFlush), .spiSelected(spiSel));
  sbr_link_sva i_sbr_link_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .selectN(link.selectN),
    .serialClock(link.serialClock), .followerToLeaderDataOe(link.followerToLeaderDataOe),
    .busy(link.busy), .readRequestFlag(link.readRequestFlag));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // bounded wait on busy or the read request flag
  task automatic wait_lvl(input bit isFlag, input logic lvl);
    int n;
    n = 0;
    while ((isFlag ? link.readRequestFlag : link.busy) !== lvl && n < 1500) begin
      @(negedge clk_sys);
      n++;
    end
    check8("level wait", {7'h00, lvl}, {7'h00, isFlag ? link.readRequestFlag : link.busy});
  endtask

  // one frame; notes the bytes each end should receive
  task automatic do_frame(input logic [7:0] len, input logic [7:0] miso, input logic skip,
                          input logic expFlag);
    int n0;
    int n;
    ldByte = 8'($random(seed));
    ignoreRx = skip || len < 8'h02;
    if (!ignoreRx) repeat (len) begin
      fq.push_back(ldByte);
      lq.push_back(miso);
    end
    n0 = flushCnt;
    n = 0;
    frameLen = len;
    startValid = 1'b1;
    while (startReady !== 1'b1 && n < 1500) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    startValid = 1'b0;
    wait_lvl(1'b0, 1'b1);
    wait_lvl(1'b0, 1'b0);
    check8("flush count", {7'h00, len < 8'h02}, 8'(flushCnt - n0));
    check8("read flag", {7'h00, expFlag}, {7'h00, link.readRequestFlag});
  endtask

  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  // registered pulses are read at the edge, so no race with their update
  always @(posedge clk_sys) begin
    if (fRxValid === 1'b1 && !ignoreRx) check8("follower rx", fq.size() > 0 ? fq.pop_front() : 8'hXX, fRx);
    if (lRxValid === 1'b1 && !ignoreRx) check8("leader rx", lq.size() > 0 ? lq.pop_front() : 8'hXX, lRx);
    if (busyTo === 1'b1) check8("busy timeout", 8'h00, 8'h01);
    if (fFlush === 1'b1) begin
      flushCnt++;
      msgPending <= 1'b0;  // message side drops flushed data for good
    end
  end

  // rebuild each leader byte from the wire, msb first
  always @(posedge link.serialClock) begin
    wireSh = {wireSh[6:0], link.leaderToFollowerData};
    wireBits++;
    if (wireBits % 8 == 0 && !ignoreRx) check8("wire byte", ldByte, wireSh);
  end

  // a new frame starts a new bit count
  always @(negedge link.selectN) wireBits = 0;

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // watchdog: the run needs well under 20000 cycles
  initial begin
    #(40000 * 25);
    bad_count++;
    $display("wrong value watchdog expected done seen hung");
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 94;
    sys_rst = 1'b1;
    {startValid, msgPending, ignoreRx} = 3'b001;
    {frameLen, ldByte, rdByte} = 24'h000000;
    linkTypeSelect = 3'h2;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      linkTypeSelect = 3'(i);
      repeat (3) @(negedge clk_sys);
      check8("spi selected", {7'h00, i == 2}, {7'h00, spiSel});
    end
    linkTypeSelect = 3'h2;
    do_frame(8'h03, sbr_pkg::FILL_BYTE, 1'b0, 1'b0);
    do_frame(8'h00, 8'h00, 1'b0, 1'b0);
    do_frame(8'h01, 8'h00, 1'b0, 1'b0);
    rdByte = 8'($random(seed));
    msgPending = 1'b1;
    wait_lvl(1'b1, 1'b1);
    do_frame(8'h02, 8'h00, 1'b1, 1'b0);
    do_frame(8'h04, rdByte, 1'b0, 1'b0);
    msgPending = 1'b0;
    do_frame(8'h02, sbr_pkg::FILL_BYTE, 1'b0, 1'b0);
    // flush before and after the acknowledge
    for (int k = 0; k < 3; k++) begin
      msgPending = 1'b1;
      wait_lvl(1'b1, 1'b1);
      if (k == 1) do_frame(8'h02, 8'h00, 1'b1, 1'b0);
      do_frame(8'(k != 0), 8'h00, 1'b0, 1'b0);
      do_frame(8'h03, sbr_pkg::FILL_BYTE, 1'b0, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      do_frame(8'h02 + 8'($random(seed) & 3), sbr_pkg::FILL_BYTE, 1'b0, 1'b0);
    end
    close_out();
  end
endmodule
